// ---- hdl/pcie_port_status_link_caps_pkg.sv ----
/*
  Shared constants, field layouts and carrier types for the per-port device
  status and link capabilities registers.
  Assumes configuration accesses arrive as dword address plus byte enables.
*/
package pcie_port_status_link_caps_pkg;

	// register offsets (byte addresses in configuration space)
	localparam logic [11:0] DEV_STATUS_OFFSET = 12'h04A;
	localparam logic [11:0] LINK_CAPS_OFFSET  = 12'h04C;
	localparam int          DW_ADDR_W         = 10;
	localparam logic [9:0]  DEV_STATUS_DW     = DEV_STATUS_OFFSET[11:2];
	localparam logic [9:0]  LINK_CAPS_DW      = LINK_CAPS_OFFSET[11:2];
	localparam int          DEV_STATUS_LANE   = 16;

	// device status field positions
	localparam int CORRECTABLE_POS   = 0;
	localparam int NONFATAL_POS      = 1;
	localparam int FATAL_POS         = 2;
	localparam int UNSUPPORTED_POS   = 3;
	localparam int AUX_POWER_POS     = 4;
	localparam int TRANS_PENDING_POS = 5;
	localparam logic [15:0] DEV_STATUS_RESET = 16'h0000;

	// link capabilities reset values
	localparam logic [3:0] MAX_LINK_SPEED_RESET   = 4'h2;
	localparam logic [5:0] MAX_LINK_WIDTH_RESET   = 6'h04;
	localparam logic [1:0] ACTIVE_PM_RESET        = 2'h3;
	localparam logic [2:0] L0S_EXIT_RESET         = 3'h6;
	localparam logic [2:0] L1_EXIT_RESET          = 3'h2;
	localparam logic       REFCLK_REMOVAL_RESET   = 1'h0;
	localparam logic       DOWNSTREAM_CAP_RESET   = 1'h1;

	// lockable bits: width 9:4, pm 11:10, l0s 14:12, l1 17:15, clock pm 18
	localparam logic [31:0] LOCKABLE_COMMON_MASK  = 32'h0007_FFF0;
	// downstream-only lockable bits 21:19
	localparam logic [31:0] LOCKABLE_DOWN_MASK    = 32'h0038_0000;

	typedef struct packed
	{
		logic unsupported;
		logic fatal;
		logic nonfatal;
		logic correctable;
	} err_events_t;

	typedef struct packed
	{
		logic [7:0] portIndex;
		logic [1:0] reserved;
		logic       bandwidthNotifyCap;
		logic       linkActiveReportCap;
		logic       surpriseDownReportCap;
		logic       refclkRemovalCapable;
		logic [2:0] l1ExitLatency;
		logic [2:0] l0sExitLatency;
		logic [1:0] activePmSupport;
		logic [5:0] maxLinkWidth;
		logic [3:0] maxLinkSpeed;
	} link_caps_t;

	typedef struct packed
	{
		logic        rd;
		logic        wr;
		logic [9:0]  dwAddr;
		logic [3:0]  byteEn;
		logic [31:0] data;
	} cfg_req_t;

	function automatic logic [31:0] byte_merge(input logic [31:0] oldV, input logic [31:0] newV,
		input logic [3:0] be);
		logic [31:0] r;
		r = oldV;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[i*8 +: 8] = newV[i*8 +: 8];
		end
		return r;
	endfunction

endpackage

// ---- hdl/err_status_flags.sv ----
/*
  Sticky error-detected flags with write-one-to-clear.
  Assumes event inputs are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/100ps
module err_status_flags
(
	input  wire logic                                         clk,
	input  wire logic                                         rstn,
	input  wire pcie_port_status_link_caps_pkg::err_events_t  events,
	input  wire logic [3:0]                                   clearMask,
	output      pcie_port_status_link_caps_pkg::err_events_t  flags
);

	pcie_port_status_link_caps_pkg::err_events_t flags_reg;
	pcie_port_status_link_caps_pkg::err_events_t flags_next;

	assign flags_next = (flags_reg & ~clearMask) | events;
	assign flags      = flags_reg;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			flags_reg <= '0;
		else
			flags_reg <= flags_next;
	end

endmodule

// ---- hdl/link_caps_fields.sv ----
/*
  Link capabilities storage with lockable fields.
  Assumes the write strobe is already decoded to this register.
*/
`timescale 1ns/100ps
module link_caps_fields
#(
	parameter int PORT_INDEX = 0
)
(
	input  wire logic                                        clk,
	input  wire logic                                        rstn,
	input  wire logic                                        wrEn,
	input  wire logic [3:0]                                  byteEn,
	input  wire logic [31:0]                                 wrData,
	input  wire logic                                        unlock,
	output      pcie_port_status_link_caps_pkg::link_caps_t  caps
);

	localparam logic       UPSTREAM  = (PORT_INDEX == 0);
	localparam logic [7:0] PORT_BYTE = PORT_INDEX[7:0];
	localparam logic [31:0] WR_MASK  = UPSTREAM ? pcie_port_status_link_caps_pkg::LOCKABLE_COMMON_MASK :
		(pcie_port_status_link_caps_pkg::LOCKABLE_COMMON_MASK | pcie_port_status_link_caps_pkg::LOCKABLE_DOWN_MASK);

	localparam logic        DOWN_CAP = UPSTREAM ? 1'h0 : pcie_port_status_link_caps_pkg::DOWNSTREAM_CAP_RESET;
	localparam logic [31:0] RESET_CAPS = {PORT_BYTE, 2'h0, DOWN_CAP, DOWN_CAP, DOWN_CAP,
		pcie_port_status_link_caps_pkg::REFCLK_REMOVAL_RESET, pcie_port_status_link_caps_pkg::L1_EXIT_RESET,
		pcie_port_status_link_caps_pkg::L0S_EXIT_RESET, pcie_port_status_link_caps_pkg::ACTIVE_PM_RESET,
		pcie_port_status_link_caps_pkg::MAX_LINK_WIDTH_RESET, pcie_port_status_link_caps_pkg::MAX_LINK_SPEED_RESET};

	pcie_port_status_link_caps_pkg::link_caps_t caps_reg;
	pcie_port_status_link_caps_pkg::link_caps_t caps_next;
	logic [31:0]                                merged;
	logic                                       wrAllowed;

	assign wrAllowed = wrEn & unlock;
	assign merged    = pcie_port_status_link_caps_pkg::byte_merge(caps_reg, wrData, byteEn);
	assign caps_next = wrAllowed ? ((merged & WR_MASK) | (caps_reg & ~WR_MASK)) : caps_reg;
	assign caps      = caps_reg;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			caps_reg <= RESET_CAPS;
		else
			caps_reg <= caps_next;
	end

endmodule

// ---- hdl/pcie_port_status_link_caps.sv ----
/*
  Device status and link capabilities registers of one switch port, with
  configuration read and write decode and error reporting gates.
  Assumes configuration accesses are single-cycle strobes on clk; the device
  control register beside the status word lives elsewhere and supplies the
  report enables.
*/
`timescale 1ns/100ps
module pcie_port_status_link_caps
#(
	parameter int PORT_INDEX = 0
)
(
	input  wire logic                                         clk,
	input  wire logic                                         rstn,
	input  wire pcie_port_status_link_caps_pkg::cfg_req_t     cfgReq,
	output      logic [31:0]                                  cfgRdData,
	output      logic                                         cfgRdValid,
	output      logic                                         cfgHit,
	input  wire pcie_port_status_link_caps_pkg::err_events_t  errEvents,
	input  wire logic                                         correctableReportEn,
	input  wire logic                                         nonfatalReportEn,
	input  wire logic                                         fatalReportEn,
	input  wire logic                                         unsupportedReportEn,
	input  wire logic                                         registerWriteUnlock,
	input  wire logic                                         dlActive,
	output      pcie_port_status_link_caps_pkg::err_events_t  errReport,
	output      pcie_port_status_link_caps_pkg::err_events_t  errFlags,
	output      logic                                         linkActiveStatus
);

	generate
		if (PORT_INDEX < 0 || PORT_INDEX > 3)
		begin : badPort
			$error("PORT_INDEX must be 0 to 3");
		end
	endgenerate

	pcie_port_status_link_caps_pkg::err_events_t flagsNow;
	pcie_port_status_link_caps_pkg::err_events_t reportEn;
	pcie_port_status_link_caps_pkg::err_events_t report_next;
	pcie_port_status_link_caps_pkg::err_events_t report_reg;
	pcie_port_status_link_caps_pkg::link_caps_t  capsNow;
	logic [3:0]                                  clearMask;
	logic [15:0]                                 statusWord;
	logic                                        statusSel;
	logic                                        capsSel;
	logic                                        statusWr;
	logic                                        capsWr;
	logic [31:0]                                 rdMux;
	logic [31:0]                                 rdData_reg;
	logic                                        rdValid_reg;
	logic                                        hit_reg;
	logic                                        linkActive_reg;

	// address decode
	assign statusSel = (cfgReq.dwAddr == pcie_port_status_link_caps_pkg::DEV_STATUS_DW);
	assign capsSel   = (cfgReq.dwAddr == pcie_port_status_link_caps_pkg::LINK_CAPS_DW);
	assign statusWr  = cfgReq.wr & statusSel;
	assign capsWr    = cfgReq.wr & capsSel;

	assign clearMask = (statusWr && cfgReq.byteEn[2]) ?
		cfgReq.data[pcie_port_status_link_caps_pkg::DEV_STATUS_LANE +: 4] : 4'h0;

	err_status_flags u_flags
	(
		.clk       (clk),
		.rstn      (rstn),
		.events    (errEvents),
		.clearMask (clearMask),
		.flags     (flagsNow)
	);

	link_caps_fields #(.PORT_INDEX(PORT_INDEX)) u_caps
	(
		.clk    (clk),
		.rstn   (rstn),
		.wrEn   (capsWr),
		.byteEn (cfgReq.byteEn),
		.wrData (cfgReq.data),
		.unlock (registerWriteUnlock),
		.caps   (capsNow)
	);

	assign statusWord = {12'h000, flagsNow};

	assign rdMux = statusSel ? {statusWord, 16'h0000} :
		capsSel ? capsNow : 32'h0000_0000;

	assign reportEn.correctable = correctableReportEn;
	assign reportEn.nonfatal    = nonfatalReportEn;
	assign reportEn.fatal       = fatalReportEn;
	assign reportEn.unsupported = unsupportedReportEn;
	assign report_next          = errEvents & reportEn;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdData_reg  <= 32'h0000_0000;
			rdValid_reg <= 1'b0;
			hit_reg     <= 1'b0;
		end
		else
		begin
			rdData_reg  <= cfgReq.rd ? rdMux : rdData_reg;
			rdValid_reg <= cfgReq.rd;
			hit_reg     <= (cfgReq.rd | cfgReq.wr) & (statusSel | capsSel);
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			report_reg     <= '0;
			linkActive_reg <= 1'b0;
		end
		else
		begin
			report_reg     <= report_next;
			linkActive_reg <= dlActive;
		end
	end

	assign cfgRdData        = rdData_reg;
	assign cfgRdValid       = rdValid_reg;
	assign cfgHit           = hit_reg;
	assign errReport        = report_reg;
	assign errFlags         = flagsNow;
	assign linkActiveStatus = linkActive_reg;

endmodule

// ---- verification/pcie_port_status_link_caps_assertions.sv ----
/*
  port-level assertions for the status and link caps block.
  assumes it is bound to pcie_port_status_link_caps, one clock domain.
*/
`timescale 1ns/100ps
module pcie_port_status_link_caps_assertions
#(
	parameter int PORT_INDEX = 0
)
(
	input wire logic                                        clk,
	input wire logic                                        rstn,
	input wire pcie_port_status_link_caps_pkg::cfg_req_t    cfgReq,
	input wire logic [31:0]                                 cfgRdData,
	input wire logic                                        cfgRdValid,
	input wire logic                                        cfgHit,
	input wire pcie_port_status_link_caps_pkg::err_events_t errEvents,
	input wire logic                                        correctableReportEn,
	input wire logic                                        nonfatalReportEn,
	input wire logic                                        fatalReportEn,
	input wire logic                                        unsupportedReportEn,
	input wire logic                                        registerWriteUnlock,
	input wire logic                                        dlActive,
	input wire pcie_port_status_link_caps_pkg::err_events_t errReport,
	input wire pcie_port_status_link_caps_pkg::err_events_t errFlags,
	input wire logic                                        linkActiveStatus
);
	wire logic [3:0] enVec = {unsupportedReportEn, fatalReportEn, nonfatalReportEn, correctableReportEn};
	wire logic       clrWr = cfgReq.wr && cfgReq.dwAddr == 10'h012 && cfgReq.byteEn[2];
	wire logic       lockWr = cfgReq.wr && cfgReq.dwAddr == 10'h013 && !registerWriteUnlock;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence sStatusRead;
		cfgReq.rd && cfgReq.dwAddr == 10'h012;
	endsequence
	sequence sCapsRead;
		cfgReq.rd && cfgReq.dwAddr == 10'h013;
	endsequence
	AST_FLAG_SET: assert property (
		|errEvents |=> (errFlags & $past(errEvents)) == $past(errEvents)) else $error("flag not set by event");
	AST_FLAG_HOLD: assert property (
		!clrWr |=> (errFlags & $past(errFlags)) == $past(errFlags)) else $error("flag dropped without clear");
	AST_W1C: assert property (
		clrWr && errEvents == 4'h0 |=> (errFlags & $past(cfgReq.data[19:16])) == 4'h0) else $error("flag not cleared");
	AST_REPORT: assert property (
		$past(rstn) |-> errReport == ($past(errEvents) & $past(enVec))) else $error("report not gated by enable");
	AST_STATUS_READ: assert property (
		sStatusRead |=> cfgRdValid && cfgHit && cfgRdData == {12'h000, $past(errFlags), 16'h0000})
		else $error("status read wrong");
	AST_CAPS_FIXED: assert property (
		sCapsRead |=> cfgRdValid && cfgHit && cfgRdData[3:0] == 4'h2 && cfgRdData[31:22] == {PORT_INDEX[7:0], 2'h0}
		&& (PORT_INDEX != 0 || cfgRdData[21:19] == 3'h0)) else $error("fixed caps field wrong");
	AST_LOCKED: assert property (
		sCapsRead ##1 lockWr ##1 sCapsRead |=> cfgRdData == $past(cfgRdData)) else $error("locked write took effect");
	AST_LINK_ACTIVE: assert property (
		$past(rstn) |-> linkActiveStatus == $past(dlActive)) else $error("link active status wrong");
endmodule

bind pcie_port_status_link_caps pcie_port_status_link_caps_assertions #(.PORT_INDEX(PORT_INDEX)) i_chk
(
	.clk(clk), .rstn(rstn), .cfgReq(cfgReq), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgHit(cfgHit),
	.errEvents(errEvents), .correctableReportEn(correctableReportEn), .nonfatalReportEn(nonfatalReportEn),
	.fatalReportEn(fatalReportEn), .unsupportedReportEn(unsupportedReportEn), .dlActive(dlActive),
	.registerWriteUnlock(registerWriteUnlock), .errReport(errReport), .errFlags(errFlags),
	.linkActiveStatus(linkActiveStatus)
);

// ---- verification/pcie_port_status_link_caps_tb.sv ----
/*
  self-checking bench for the status and link caps block, port 2.
  assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
module pcie_port_status_link_caps_tb;
	logic                                        clk = 1'h0;
	logic                                        rstn = 1'h0;
	pcie_port_status_link_caps_pkg::cfg_req_t    req = '0;
	pcie_port_status_link_caps_pkg::err_events_t ev = '0;
	pcie_port_status_link_caps_pkg::err_events_t rep;
	pcie_port_status_link_caps_pkg::err_events_t flags;
	logic [3:0]                                  en = 4'h0;
	logic                                        unlock = 1'h0;
	logic                                        dl = 1'h0;
	logic [31:0]                                 rdData;
	logic                                        rdValid;
	logic                                        hit;
	logic                                        linkAct;
	int                                          errors = 0;
	int                                          samples_checked = 0;
	localparam logic [31:0] CAPS_DEF = 32'h0239_6C42;

	always #4 clk = ~clk;

	pcie_port_status_link_caps #(.PORT_INDEX(2)) i_dut
	(
		.clk(clk), .rstn(rstn), .cfgReq(req), .cfgRdData(rdData), .cfgRdValid(rdValid), .cfgHit(hit),
		.errEvents(ev), .correctableReportEn(en[0]), .nonfatalReportEn(en[1]), .fatalReportEn(en[2]),
		.unsupportedReportEn(en[3]), .registerWriteUnlock(unlock), .dlActive(dl), .errReport(rep),
		.errFlags(flags), .linkActiveStatus(linkAct)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one request per cycle, answer sampled just after the next edge
	task automatic op(input logic r, input logic w, input logic [9:0] a, input logic [3:0] be,
		input logic [31:0] d, input logic [3:0] e);
		req = '{r, w, a, be, d};
		ev = e;
		@(posedge clk);
		#1;
	endtask

	task automatic t_defaults();
		op(1, 0, 10'h013, 4'hF, 0, 0);
		check(rdData, CAPS_DEF);
		check({hit, rdValid}, 2'h3);
		op(1, 0, 10'h012, 4'hF, 0, 0);
		check(rdData, 32'h0);
	endtask

	task automatic t_errors();
		for (int i = 0; i < 4; i++)
		begin
			op(0, 0, 10'h0, 4'h0, 0, 4'h1 << i);
			check(flags, (32'h2 << i) - 32'h1);
			check(rep, 32'h0);
		end
		en = 4'hF;
		op(0, 0, 10'h0, 4'h0, 0, 4'h5);
		check(rep, 32'h5);
		op(0, 1, 10'h012, 4'h4, 32'hFFF5_0000, 4'h1);
		check(flags, 32'hB);
		op(0, 1, 10'h012, 4'hB, 32'hFFFF_FFFF, 4'h0);
		check(flags, 32'hB);
		op(1, 0, 10'h012, 4'hF, 0, 0);
		check(rdData, 32'h000B_0000);
		op(0, 1, 10'h012, 4'h4, 32'h000F_0000, 4'h0);
		check(flags, 32'h0);
	endtask

	task automatic t_lock();
		op(1, 0, 10'h013, 4'hF, 0, 0);
		op(0, 1, 10'h013, 4'hF, 32'hFFFF_FFFF, 0);
		op(1, 0, 10'h013, 4'hF, 0, 0);
		check(rdData, CAPS_DEF);
		unlock = 1'h1;
		op(0, 1, 10'h013, 4'hF, 32'hFFFF_FFFF, 0);
		op(1, 0, 10'h013, 4'hF, 0, 0);
		check(rdData, 32'h023F_FFF2);
		op(0, 1, 10'h013, 4'h4, 32'h0, 0);
		op(1, 0, 10'h013, 4'hF, 0, 0);
		check(rdData, 32'h0200_FFF2);
		dl = 1'h1;
		op(0, 0, 10'h0, 4'h0, 0, 0);
		check(linkAct, 32'h1);
	endtask

	task automatic print_verdict();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		rstn = 1'h1;
		t_defaults();
		t_errors();
		t_lock();
		print_verdict();
	end

	// watchdog, far beyond the few dozen cycles the tests take
	initial
	begin
		#20000;
		errors++;
		print_verdict();
	end
endmodule
